/* design/wtbac_defines.vh */
/*
 * constants of the 16-bit byte-accessed timer core: register offsets,
 * field positions, reset values, fixed tops and clock select codes.
 * assumes an 8-bit register bus, one byte per offset.
 */
// Contract
// - counter, compares, capture: 16 bits, two byte accesses
// - one shared high-byte latch for all wide registers
// - low-byte write loads latch plus low byte together
// - low-byte read copies high byte into latch
// - compare reads bypass the latch
// - bottom at 0x0000, maximum at 0xFFFF
// - top fixed, compare A or capture by mode
// - compare A as PWM top: no PWM, buffered
// - compare buffers compared against counter on each timer tick
// - compare match sets that channel's match flag
// - each channel drives a PWM or frequency waveform
// - selected capture edge copies counter to capture, except while capture is top
// - optional noise filter on the capture path
// - tick from prescaler or pin; none stops counter
// - four flags visible, each masked individually
// - control registers plain bytes, no latch
// - four-bit wave mode field and force strobes
// - software counter write beats counting
// - capture flag set with the capture copy
// - capture writable only when used as top
`ifndef WTBAC_DEFINES_VH
`define WTBAC_DEFINES_VH

// ==========================================================
// register offsets
`define WTBAC_ADR_CTRL_A 4'h0
`define WTBAC_ADR_CTRL_B 4'h1
`define WTBAC_ADR_CTRL_C 4'h2
`define WTBAC_ADR_CNT_LO 4'h3
`define WTBAC_ADR_CNT_HI 4'h4
`define WTBAC_ADR_CA_LO  4'h5
`define WTBAC_ADR_CA_HI  4'h6
`define WTBAC_ADR_CB_LO  4'h7
`define WTBAC_ADR_CB_HI  4'h8
`define WTBAC_ADR_CAP_LO 4'h9
`define WTBAC_ADR_CAP_HI 4'hA
`define WTBAC_ADR_FLAG   4'hB
`define WTBAC_ADR_MASK   4'hC

// ==========================================================
// reset values and counter landmarks
`define WTBAC_RST8   8'h00
`define WTBAC_RST16  16'h0000
`define WTBAC_BOTTOM 16'h0000
`define WTBAC_MAX    16'hFFFF
`define WTBAC_TOP8   16'h00FF
`define WTBAC_TOP9   16'h01FF
`define WTBAC_TOP10  16'h03FF

// ==========================================================
// field positions
`define WTBAC_CA_COMA 7:6
`define WTBAC_CA_COMB 5:4
`define WTBAC_CA_WMLO 1:0
`define WTBAC_CB_FILT 7
`define WTBAC_CB_EDGE 6
`define WTBAC_CB_SRC  5
`define WTBAC_CB_WMHI 4:3
`define WTBAC_CB_CS   2:0
`define WTBAC_CC_FRCA 7
`define WTBAC_CC_FRCB 6
`define WTBAC_FL_WRAP 0
`define WTBAC_FL_MA   1
`define WTBAC_FL_MB   2
`define WTBAC_FL_CAP  3

// ==========================================================
// clock select codes and prescaler tap masks
`define WTBAC_CS_STOP  3'h0
`define WTBAC_CS_DIV1  3'h1
`define WTBAC_CS_DIV8  3'h2
`define WTBAC_CS_DIV64 3'h3
`define WTBAC_CS_D256  3'h4
`define WTBAC_CS_D1024 3'h5
`define WTBAC_CS_FALL  3'h6
`define WTBAC_CS_RISE  3'h7
`define WTBAC_PRE8     10'h007
`define WTBAC_PRE64    10'h03F
`define WTBAC_PRE256   10'h0FF
`define WTBAC_PRE1024  10'h3FF
`define WTBAC_FILT_N   4

`endif

/* design/wtbac_pin_cond.v */
/*
 * pin conditioner: two-stage synchroniser, optional majority-free
 * noise filter (level must hold for a run of samples) and edge pulses.
 * assumes an asynchronous pin and the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wtbac_defines.vh"

module wtbac_pin_cond (
	input  wire core_clk_in,  // core clock
	input  wire rst_n_in,     // async reset, low
	input  wire pin_in,       // raw pin
	input  wire filt_en_in,   // noise filter on
	output reg  rise_out,     // one-cycle rising pulse
	output reg  fall_out      // one-cycle falling pulse
);

	// ==========================================================
	// synchroniser and filter state
	reg                      meta_q;  // first stage, read by sync_q only
	reg                      sync_q;  // second stage
	reg [`WTBAC_FILT_N-1:0]  hist_q;  // recent samples
	reg                      lvl_q;   // conditioned level
	reg                      lvl_d;   // next conditioned level

	// filter: the level only moves when all samples agree
	always @* begin
		lvl_d = lvl_q;
		if (!filt_en_in)
			lvl_d = sync_q;
		else if (&hist_q)
			lvl_d = 1'b1;
		else if (~|hist_q)
			lvl_d = 1'b0;
	end

	// sample, filter and detect edges
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_q   <= 1'b0;
			sync_q   <= 1'b0;
			hist_q   <= {`WTBAC_FILT_N{1'b0}};
			lvl_q    <= 1'b0;
			rise_out <= 1'b0;
			fall_out <= 1'b0;
		end else begin
			meta_q   <= pin_in;
			sync_q   <= meta_q;
			hist_q   <= {hist_q[`WTBAC_FILT_N-2:0], sync_q};
			lvl_q    <= lvl_d;
			rise_out <= lvl_d & ~lvl_q;
			fall_out <= ~lvl_d & lvl_q;
		end
	end

endmodule // wtbac_pin_cond
`default_nettype wire

/* design/wtbac_core.v */
/*
 * 16-bit timer core: counter, two buffered compare channels with
 * waveform outputs, one filtered capture channel, four flags, byte
 * access through one shared high-byte latch over Avalon-MM.
 * assumes an 8-bit Avalon master and asynchronous pins.
 */
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "wtbac_defines.vh"

module wtbac_core (
	input  wire       core_clk_in,          // 25 MHz core clock
	input  wire       rst_n_in,             // async reset, low
	input  wire [3:0] avs_address_in,       // byte register index
	input  wire       avs_read_in,          // read request
	input  wire       avs_write_in,         // write request
	input  wire [7:0] avs_writedata_in,     // write byte
	output reg  [7:0] avs_readdata_out,     // read byte
	output reg        avs_waitrequest_out,  // stall, high idle
	input  wire       ext_count_pin_in,     // external count pin
	input  wire       capture_pin_in,       // capture pin
	input  wire       comp_out_in,          // comparator output
	output reg        wave_out_a_out,       // channel A waveform
	output reg        wave_out_b_out,       // channel B waveform
	output reg  [3:0] irq_req_out           // masked requests
);

	// ==========================================================
	// mode kinds
	localparam [1:0] K_NORM = 2'b00;  // free run to max
	localparam [1:0] K_CTC  = 2'b01;  // clear at top
	localparam [1:0] K_FAST = 2'b10;  // single slope pwm
	localparam [1:0] K_DUAL = 2'b11;  // dual slope pwm

	// ==========================================================
	// registers
	reg  [7:0]  ctrl_a_q;    // timer_ctrl_a
	reg  [7:0]  ctrl_b_q;    // timer_ctrl_b
	reg  [15:0] count_q;     // count_value
	reg  [15:0] cbuf_a_q;    // compare_value_a, software side
	reg  [15:0] cbuf_b_q;    // compare_value_b, software side
	reg  [15:0] cact_a_q;    // compare A in use
	reg  [15:0] cact_b_q;    // compare B in use
	reg  [15:0] cap_q;       // capture_value
	reg  [7:0]  latch_q;     // shared high-byte latch
	reg  [3:0]  flag_q;      // timer_flag_reg
	reg  [3:0]  mask_q;      // timer_mask_reg
	reg  [9:0]  pre_q;       // free-running prescaler
	reg         down_q;      // dual slope: counting down
	reg  [1:0]  wave_q;      // waveform levels, bit per channel

	// ==========================================================
	// decoded mode
	wire [3:0]  wave_mode_field;  // four-bit mode
	reg  [1:0]  kind;             // counting kind
	reg  [15:0] top_v;            // top of sequence
	reg         top_ca;           // compare A is top
	reg         top_cap;          // capture is top
	wire        pwm;              // pwm kinds

	// ==========================================================
	// bus decode
	wire        bus_req;   // any request
	wire        rd_take;   // read data loaded this cycle
	wire        wr_do;     // write takes effect this cycle
	wire [15:0] wr_word;   // latch and written byte

	// ==========================================================
	// timing and events
	reg         tick;       // timer_tick
	wire        at_top;     // counter at top
	wire        at_bot;     // counter at bottom
	wire        at_max;     // counter at maximum
	wire        upd;        // compare buffers move to use
	wire        wrap_ev;    // sets wrap_flag
	wire [1:0]  match;      // compare matches
	wire [1:0]  force_m;    // force strobes
	wire [31:0] cmp_v;      // compare values per channel
	wire [3:0]  com_v;      // output modes per channel
	wire        ext_rise;   // external pin edges
	wire        ext_fall;
	wire        cpin_rise;  // capture pin edges
	wire        cpin_fall;
	wire        comp_rise;  // comparator edges
	wire        comp_fall;
	wire        cap_rise;   // selected source edges
	wire        cap_fall;
	wire        cap_ev;     // capture trigger
	wire [3:0]  flag_set;   // hardware flag sets
	wire [3:0]  flag_clr;   // software flag clears

	// ==========================================================
	// pin conditioning
	wtbac_pin_cond u_ext (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.pin_in      (ext_count_pin_in),
		.filt_en_in  (1'b0),
		.rise_out    (ext_rise),
		.fall_out    (ext_fall)
	);

	// capture pin, filter on request
	wtbac_pin_cond u_cpin (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.pin_in      (capture_pin_in),
		.filt_en_in  (ctrl_b_q[`WTBAC_CB_FILT]),
		.rise_out    (cpin_rise),
		.fall_out    (cpin_fall)
	);

	// comparator output as alternate capture source
	wtbac_pin_cond u_comp (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.pin_in      (comp_out_in),
		.filt_en_in  (ctrl_b_q[`WTBAC_CB_FILT]),
		.rise_out    (comp_rise),
		.fall_out    (comp_fall)
	);

	// ==========================================================
	// mode decode: fixed tops, compare A or capture as top
	assign wave_mode_field = {ctrl_b_q[`WTBAC_CB_WMHI],
		ctrl_a_q[`WTBAC_CA_WMLO]};
	always @* begin
		kind    = K_NORM;
		top_v   = `WTBAC_MAX;
		top_ca  = 1'b0;
		top_cap = 1'b0;
		case (wave_mode_field)
		4'h1: begin kind = K_DUAL; top_v = `WTBAC_TOP8; end
		4'h2: begin kind = K_DUAL; top_v = `WTBAC_TOP9; end
		4'h3: begin kind = K_DUAL; top_v = `WTBAC_TOP10; end
		4'h4: begin kind = K_CTC; top_ca = 1'b1; end
		4'h5: begin kind = K_FAST; top_v = `WTBAC_TOP8; end
		4'h6: begin kind = K_FAST; top_v = `WTBAC_TOP9; end
		4'h7: begin kind = K_FAST; top_v = `WTBAC_TOP10; end
		4'h8, 4'hA: begin kind = K_DUAL; top_cap = 1'b1; end
		4'h9, 4'hB: begin kind = K_DUAL; top_ca = 1'b1; end
		4'hC: begin kind = K_CTC; top_cap = 1'b1; end
		4'hE: begin kind = K_FAST; top_cap = 1'b1; end
		4'hF: begin kind = K_FAST; top_ca = 1'b1; end
		default: kind = K_NORM;
		endcase
		if (top_ca)
			top_v = cact_a_q;
		else if (top_cap)
			top_v = cap_q;
	end
	assign pwm = kind[1];

	// ==========================================================
	// prescaler and clock select
	always @* begin
		case (ctrl_b_q[`WTBAC_CB_CS])
		`WTBAC_CS_STOP:  tick = 1'b0;
		`WTBAC_CS_DIV1:  tick = 1'b1;
		`WTBAC_CS_DIV8:
			tick = (pre_q & `WTBAC_PRE8) == `WTBAC_PRE8;
		`WTBAC_CS_DIV64:
			tick = (pre_q & `WTBAC_PRE64) == `WTBAC_PRE64;
		`WTBAC_CS_D256:
			tick = (pre_q & `WTBAC_PRE256) == `WTBAC_PRE256;
		`WTBAC_CS_D1024:
			tick = pre_q == `WTBAC_PRE1024;
		`WTBAC_CS_FALL:  tick = ext_fall;
		`WTBAC_CS_RISE:  tick = ext_rise;
		default:         tick = 1'b0;
		endcase
	end

	// ==========================================================
	// avalon slave: one stall cycle, then the answer
	assign bus_req = avs_read_in | avs_write_in;
	assign rd_take = avs_read_in & avs_waitrequest_out;
	assign wr_do   = avs_write_in & ~avs_waitrequest_out;
	assign wr_word = {latch_q, avs_writedata_in};

	// waitrequest drops one cycle after a request appears
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			avs_waitrequest_out <= 1'b1;
		else
			avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
	end

	// read data mux, loaded in the stall cycle
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			avs_readdata_out <= `WTBAC_RST8;
		end else if (rd_take) begin
			case (avs_address_in)
			`WTBAC_ADR_CTRL_A: avs_readdata_out <= ctrl_a_q;
			`WTBAC_ADR_CTRL_B: avs_readdata_out <= ctrl_b_q;
			`WTBAC_ADR_CNT_LO: avs_readdata_out <= count_q[7:0];
			`WTBAC_ADR_CNT_HI: avs_readdata_out <= latch_q;
			`WTBAC_ADR_CA_LO:  avs_readdata_out <= cbuf_a_q[7:0];
			`WTBAC_ADR_CA_HI:  avs_readdata_out <= cbuf_a_q[15:8];
			`WTBAC_ADR_CB_LO:  avs_readdata_out <= cbuf_b_q[7:0];
			`WTBAC_ADR_CB_HI:  avs_readdata_out <= cbuf_b_q[15:8];
			`WTBAC_ADR_CAP_LO: avs_readdata_out <= cap_q[7:0];
			`WTBAC_ADR_CAP_HI: avs_readdata_out <= latch_q;
			`WTBAC_ADR_FLAG:   avs_readdata_out <= {4'h0, flag_q};
			`WTBAC_ADR_MASK:   avs_readdata_out <= {4'h0, mask_q};
			default:           avs_readdata_out <= `WTBAC_RST8;
			endcase
		end
	end

	// ==========================================================
	// shared latch: high-byte writes and low-byte reads
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			latch_q <= `WTBAC_RST8;
		end else if (wr_do) begin
			case (avs_address_in)
			`WTBAC_ADR_CNT_HI, `WTBAC_ADR_CA_HI,
			`WTBAC_ADR_CB_HI, `WTBAC_ADR_CAP_HI:
				latch_q <= avs_writedata_in;
			default: latch_q <= latch_q;
			endcase
		end else if (rd_take) begin
			case (avs_address_in)
			`WTBAC_ADR_CNT_LO: latch_q <= count_q[15:8];
			`WTBAC_ADR_CAP_LO: latch_q <= cap_q[15:8];
			default:           latch_q <= latch_q;
			endcase
		end
	end

	// control and mask bytes, plain writes
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_a_q <= `WTBAC_RST8;
			ctrl_b_q <= `WTBAC_RST8;
			mask_q   <= 4'h0;
		end else if (wr_do) begin
			case (avs_address_in)
			`WTBAC_ADR_CTRL_A: ctrl_a_q <= avs_writedata_in;
			`WTBAC_ADR_CTRL_B: ctrl_b_q <= avs_writedata_in;
			`WTBAC_ADR_MASK:   mask_q <= avs_writedata_in[3:0];
			default:           ctrl_a_q <= ctrl_a_q;
			endcase
		end
	end

	// ==========================================================
	// counter landmarks and events
	assign at_top  = count_q == top_v;
	assign at_bot  = count_q == `WTBAC_BOTTOM;
	assign at_max  = count_q == `WTBAC_MAX;
	assign wrap_ev = tick & ((kind == K_FAST) ? at_top :
		(kind == K_DUAL) ? (at_bot & down_q) : at_max);
	assign upd     = ~pwm | (tick & ((kind == K_FAST) ? at_top : at_bot));
	assign cmp_v   = {cact_b_q, cact_a_q};
	assign com_v   = {ctrl_a_q[`WTBAC_CA_COMB], ctrl_a_q[`WTBAC_CA_COMA]};
	assign force_m = {2{wr_do & (avs_address_in == `WTBAC_ADR_CTRL_C)
		& ~pwm}} & {avs_writedata_in[`WTBAC_CC_FRCB],
		avs_writedata_in[`WTBAC_CC_FRCA]};

	// counter: software write first, else count on tick
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_q <= `WTBAC_RST16;
			down_q  <= 1'b0;
		end else if (wr_do && avs_address_in == `WTBAC_ADR_CNT_LO) begin
			count_q <= wr_word;
		end else if (tick) begin
			case (kind)
			K_CTC, K_FAST:
				count_q <= at_top ? `WTBAC_BOTTOM : count_q + 16'h0001;
			K_DUAL: begin
				if (!down_q && at_top) begin
					count_q <= count_q - 16'h0001;
					down_q  <= 1'b1;
				end else if (down_q && at_bot) begin
					count_q <= count_q + 16'h0001;
					down_q  <= 1'b0;
				end else if (down_q) begin
					count_q <= count_q - 16'h0001;
				end else begin
					count_q <= count_q + 16'h0001;
				end
			end
			default: count_q <= count_q + 16'h0001;
			endcase
		end
	end

	// ==========================================================
	// compare buffers: software side and in-use side
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cbuf_a_q <= `WTBAC_RST16;
			cbuf_b_q <= `WTBAC_RST16;
			cact_a_q <= `WTBAC_RST16;
			cact_b_q <= `WTBAC_RST16;
		end else begin
			if (wr_do && avs_address_in == `WTBAC_ADR_CA_LO)
				cbuf_a_q <= wr_word;
			if (wr_do && avs_address_in == `WTBAC_ADR_CB_LO)
				cbuf_b_q <= wr_word;
			if (upd) begin
				cact_a_q <= cbuf_a_q;
				cact_b_q <= cbuf_b_q;
			end
		end
	end

	// ==========================================================
	// capture unit
	assign cap_rise = ctrl_b_q[`WTBAC_CB_SRC] ? comp_rise : cpin_rise;
	assign cap_fall = ctrl_b_q[`WTBAC_CB_SRC] ? comp_fall : cpin_fall;
	assign cap_ev   = ~top_cap &
		(ctrl_b_q[`WTBAC_CB_EDGE] ? cap_rise : cap_fall);

	// capture copy, or software write when it serves as top
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			cap_q <= `WTBAC_RST16;
		else if (cap_ev)
			cap_q <= count_q;
		else if (wr_do && avs_address_in == `WTBAC_ADR_CAP_LO
			&& top_cap)
			cap_q <= wr_word;
	end

	// ==========================================================
	// compare channels and waveform generators
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
			// continuous compare, qualified by the tick
			assign match[ch] = tick &
				(count_q == cmp_v[ch*16 +: 16]);

			// waveform level per channel
			always @(posedge core_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					wave_q[ch] <= 1'b0;
				end else if (pwm && ch == 0 && top_ca) begin
					if (match[ch] && com_v[2*ch +: 2] == 2'b01)
						wave_q[ch] <= ~wave_q[ch];
				end else if (pwm && com_v[2*ch+1]) begin
					if (match[ch])
						wave_q[ch] <= com_v[2*ch] ^
							((kind == K_DUAL) & down_q);
					else if (kind == K_FAST && wrap_ev)
						wave_q[ch] <= ~com_v[2*ch];
				end else if (!pwm && (match[ch] || force_m[ch])) begin
					case (com_v[2*ch +: 2])
					2'b01:   wave_q[ch] <= ~wave_q[ch];
					2'b10:   wave_q[ch] <= 1'b0;
					2'b11:   wave_q[ch] <= 1'b1;
					default: wave_q[ch] <= wave_q[ch];
					endcase
				end
			end
		end
	endgenerate

	// ==========================================================
	// flags: set wins over a write-one clear
	assign flag_set = {cap_ev, match[1], match[0], wrap_ev};
	assign flag_clr = (wr_do && avs_address_in == `WTBAC_ADR_FLAG) ?
		avs_writedata_in[3:0] : 4'h0;

	// flags, prescaler, outputs
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flag_q         <= 4'h0;
			pre_q          <= 10'h000;
			irq_req_out    <= 4'h0;
			wave_out_a_out <= 1'b0;
			wave_out_b_out <= 1'b0;
		end else begin
			flag_q         <= (flag_q & ~flag_clr) | flag_set;
			pre_q          <= pre_q + 10'h001;
			irq_req_out    <= flag_q & mask_q;
			wave_out_a_out <= wave_q[0];
			wave_out_b_out <= wave_q[1];
		end
	end

endmodule // wtbac_core
`default_nettype wire

/* sim/wtbac_cpu_model.sv */
/*
 * processor model: single-threaded 8-bit master on the Avalon bus.
 * assumes a synchronous slave with waitrequest, one clock.
 */
`timescale 1ns/1ps
`default_nettype none

module wtbac_cpu_model (
	input  wire logic       core_clk_in, // core clock
	input  wire logic       wait_in,     // slave stall
	input  wire logic [7:0] rdata_in,    // read byte
	output var  logic [3:0] addr_out,    // register index
	output var  logic       rd_out,      // read request
	output var  logic       wr_out,      // write request
	output var  logic [7:0] wdata_out    // write byte
);
	initial begin
		addr_out = 4'h0;
		rd_out = 1'b0;
		wr_out = 1'b0;
		wdata_out = 8'h00;
	end

	// ==========================================================
	// one byte access; one at a time, so no handler breaks a pair
	task automatic acc(input logic w, input logic [3:0] a,
		input logic [7:0] d, output logic [7:0] q);
		addr_out <= a;
		wdata_out <= d;
		rd_out <= !w;
		wr_out <= w;
		@(posedge core_clk_in);
		while (wait_in) @(posedge core_clk_in);
		q = rdata_in;
		rd_out <= 1'b0;
		wr_out <= 1'b0;
		@(posedge core_clk_in);
	endtask

	// high byte first on writes, low byte first on reads
	task automatic wr16(input logic [3:0] a, input logic [15:0] v);
		logic [7:0] q;
		acc(1'b1, a + 4'h1, v[15:8], q);
		acc(1'b1, a, v[7:0], q);
	endtask

	task automatic rd16(input logic [3:0] a, output logic [15:0] v);
		acc(1'b0, a, 8'h00, v[7:0]);
		acc(1'b0, a + 4'h1, 8'h00, v[15:8]);
	endtask
endmodule // wtbac_cpu_model

`default_nettype wire

/* sim/wtbac_core_assertions.sv */
/*
 * checker of the timer core bus and request ports.
 * assumes mode 0 while compare A is read back.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wtbac_defines.vh"

module wtbac_core_assertions (
	input wire logic       core_clk_in,
	input wire logic       rst_n_in,
	input wire logic [3:0] avs_address_in,
	input wire logic       avs_read_in,
	input wire logic       avs_write_in,
	input wire logic [7:0] avs_writedata_in,
	input wire logic [7:0] avs_readdata_out,
	input wire logic       avs_waitrequest_out,
	input wire logic [3:0] irq_req_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	logic [7:0]  lat_q;  // shadow of the shared latch
	logic        latv_q; // shadow known
	logic [15:0] ca_q;   // shadow of compare A
	logic        cav_q;  // compare shadow known
	logic [7:0]  ctla_q; // shadow of control A
	logic [3:0]  msk_q;  // shadow of the mask
	wire wdone = avs_write_in && !avs_waitrequest_out;
	wire rdone = avs_read_in && !avs_waitrequest_out;

	// ==========================================================
	// shadows follow completed transfers
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lat_q <= 8'h00;
			latv_q <= 1'b1;
			ca_q <= 16'h0000;
			cav_q <= 1'b1;
			ctla_q <= 8'h00;
			msk_q <= 4'h0;
		end else if (wdone) begin
			case (avs_address_in)
				`WTBAC_ADR_CNT_HI, `WTBAC_ADR_CA_HI,
				`WTBAC_ADR_CB_HI, `WTBAC_ADR_CAP_HI: begin
					lat_q <= avs_writedata_in;
					latv_q <= 1'b1;
				end
				`WTBAC_ADR_CA_LO: begin
					ca_q <= {lat_q, avs_writedata_in};
					cav_q <= latv_q;
				end
				`WTBAC_ADR_CTRL_A: ctla_q <= avs_writedata_in;
				`WTBAC_ADR_MASK: msk_q <= avs_writedata_in[3:0];
				default: ;
			endcase
		end else if (rdone && (avs_address_in == `WTBAC_ADR_CNT_LO
			|| avs_address_in == `WTBAC_ADR_CAP_LO)) begin
			latv_q <= 1'b0;
		end
	end

	sequence s_rd(logic [3:0] a);
		rdone && avs_address_in == a;
	endsequence

	// ==========================================================
	// bus handshake and register views
	a_ans_next: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out) else $error("no answer next cycle");
	a_ans_once: assert property (!avs_waitrequest_out |=> avs_waitrequest_out) else $error("answer stands too long");
	a_idle_wait: assert property (!(avs_read_in || avs_write_in) && avs_waitrequest_out |=> avs_waitrequest_out) else $error("answer without request");
	a_rd_stable: assert property (!(avs_read_in && avs_waitrequest_out) |=> $stable(avs_readdata_out)) else $error("read data moved");
	a_unmap_zero: assert property (rdone && avs_address_in > `WTBAC_ADR_MASK |-> avs_readdata_out == 8'h00) else $error("unmapped read not zero");
	a_frc_zero: assert property (s_rd(`WTBAC_ADR_CTRL_C) |-> avs_readdata_out == 8'h00) else $error("force strobes read back");
	a_ctrl_echo: assert property (s_rd(`WTBAC_ADR_CTRL_A) |-> avs_readdata_out == ctla_q) else $error("control A readback");
	a_cmp_direct: assert property (s_rd(`WTBAC_ADR_CA_HI) ##0 cav_q |-> avs_readdata_out == ca_q[15:8]) else $error("compare high read");
	a_irq_masked: assert property ((irq_req_out & ~(msk_q | $past(msk_q))) == 4'h0) else $error("unmasked request");
endmodule // wtbac_core_assertions

bind wtbac_core wtbac_core_assertions u_chk (.core_clk_in(core_clk_in),
	.rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
	.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_writedata_in(avs_writedata_in),
	.avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out), .irq_req_out(irq_req_out));

`default_nettype wire

/* sim/wide_timer_byte_access_core_tb.sv */
/*
 * self-checking bench of the timer core, random values, fixed seed.
 * assumes the processor model drives the bus.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wtbac_defines.vh"

module wide_timer_byte_access_core_tb;
	logic core_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic ext_pin = 1'b0;  // count pin
	logic cap_pin = 1'b0;  // capture pin
	logic comp_pin = 1'b0; // comparator level
	logic [3:0] adr;
	logic rd, wr, wt, wa, wb;
	logic [7:0] wdat, rdat, q;
	logic [3:0] irq;
	logic [15:0] v, w, r;
	int err_count = 0;
	int n_checks = 0;

	always #20 core_clk_in = ~core_clk_in;

	wtbac_cpu_model cpu (.core_clk_in(core_clk_in), .wait_in(wt),
		.rdata_in(rdat), .addr_out(adr), .rd_out(rd), .wr_out(wr),
		.wdata_out(wdat));
	wtbac_core uut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wdat), .avs_readdata_out(rdat),
		.avs_waitrequest_out(wt), .ext_count_pin_in(ext_pin),
		.capture_pin_in(cap_pin), .comp_out_in(comp_pin),
		.wave_out_a_out(wa), .wave_out_b_out(wb), .irq_req_out(irq));

	// ==========================================================
	// comparison and verdict
	function automatic logic [15:0] pair(input logic [7:0] h, l);
		return {h, l};
	endfunction

	task automatic chk(input string nm, input logic [15:0] s, e);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// watchdog well past the planned run
	initial begin
		repeat (20000) @(posedge core_clk_in);
		err_count++;
		conclude();
	end

	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(12));
		repeat (12) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		@(posedge core_clk_in);
		for (int a = 0; a < 16; a++) begin
			cpu.acc(1'b0, a[3:0], 8'h00, q);
			chk("reset", {8'h00, q}, 16'h0000);
		end
		repeat (4) begin
			v = 16'($urandom);
			cpu.acc(1'b1, `WTBAC_ADR_CTRL_A, v[7:0] & 8'hF0, q);
			cpu.acc(1'b1, `WTBAC_ADR_CTRL_B, v[15:8] & 8'hE0, q);
			cpu.acc(1'b0, `WTBAC_ADR_CTRL_B, 8'h00, q);
			chk("ctrl_b", {8'h00, q}, {8'h00, v[15:8] & 8'hE0});
			cpu.acc(1'b0, `WTBAC_ADR_CTRL_A, 8'h00, q);
			chk("ctrl_a", {8'h00, q}, {8'h00, v[7:0] & 8'hF0});
		end
		cpu.acc(1'b1, `WTBAC_ADR_CTRL_C, 8'hC0, q);
		@(posedge core_clk_in);
		chk("waves", {14'h0, wa, wb}, {14'h0, v[6], v[4]});
		cpu.acc(1'b1, `WTBAC_ADR_CTRL_B, 8'h00, q);
		cpu.wr16(`WTBAC_ADR_CAP_LO, 16'($urandom));
		cpu.rd16(`WTBAC_ADR_CAP_LO, r);
		chk("cap_locked", r, 16'h0000);
		v = 16'($urandom);
		w = 16'($urandom);
		cpu.wr16(`WTBAC_ADR_CNT_LO, v);
		cpu.acc(1'b1, `WTBAC_ADR_CNT_HI, w[15:8], q);
		repeat (10) @(posedge core_clk_in);
		cpu.rd16(`WTBAC_ADR_CNT_LO, r);
		chk("cnt", r, v);
		cpu.wr16(`WTBAC_ADR_CA_LO, w);
		cpu.wr16(`WTBAC_ADR_CB_LO, v);
		cpu.acc(1'b1, `WTBAC_ADR_CNT_HI, ~v[15:8], q);
		cpu.acc(1'b0, `WTBAC_ADR_CB_HI, 8'h00, q);
		chk("cb_hi", {8'h00, q}, {8'h00, v[15:8]});
		cpu.acc(1'b0, `WTBAC_ADR_CA_HI, 8'h00, q);
		chk("ca_hi", {8'h00, q}, {8'h00, w[15:8]});
		cpu.acc(1'b0, `WTBAC_ADR_CA_LO, 8'h00, q);
		chk("ca_lo", {8'h00, q}, {8'h00, w[7:0]});
		// external pin edges only count while selected
		cpu.acc(1'b1, `WTBAC_ADR_CTRL_B, `WTBAC_CS_RISE, q);
		repeat (3) begin
			@(posedge core_clk_in);
			ext_pin <= 1'b1;
			repeat (4) @(posedge core_clk_in);
			ext_pin <= 1'b0;
			repeat (4) @(posedge core_clk_in);
		end
		cpu.acc(1'b1, `WTBAC_ADR_CTRL_B, 8'h00, q);
		cpu.rd16(`WTBAC_ADR_CNT_LO, r);
		chk("ext_count", r, v + 16'h0003);
		// run through both matches and the wrap
		cpu.wr16(`WTBAC_ADR_CNT_LO, 16'hFFF0);
		cpu.wr16(`WTBAC_ADR_CA_LO, 16'hFFF8);
		cpu.wr16(`WTBAC_ADR_CB_LO, 16'hFFF9);
		cpu.acc(1'b1, `WTBAC_ADR_CTRL_B, `WTBAC_CS_DIV1, q);
		repeat (40) @(posedge core_clk_in);
		cpu.acc(1'b1, `WTBAC_ADR_CTRL_B, 8'h00, q);
		cpu.acc(1'b0, `WTBAC_ADR_FLAG, 8'h00, q);
		chk("flags", {12'h000, q[3:0]}, 16'h0007);
		chk("irq_off", {12'h000, irq}, 16'h0000);
		cpu.acc(1'b1, `WTBAC_ADR_MASK, 8'h05, q);
		repeat (2) @(posedge core_clk_in);
		chk("irq_on", {12'h000, irq}, 16'h0005);
		cpu.acc(1'b1, `WTBAC_ADR_FLAG, 8'h0F, q);
		repeat (2) @(posedge core_clk_in);
		chk("irq_clr", {12'h000, irq}, 16'h0000);
		// capture from the pin, then from the comparator
		for (int s = 0; s < 2; s++) begin
			v = 16'($urandom);
			cpu.wr16(`WTBAC_ADR_CNT_LO, v);
			cpu.acc(1'b1, `WTBAC_ADR_CTRL_B, s ? 8'h60 : 8'h40, q);
			@(posedge core_clk_in);
			cap_pin <= (s == 0);
			comp_pin <= (s == 1);
			repeat (8) @(posedge core_clk_in);
			cap_pin <= 1'b0;
			comp_pin <= 1'b0;
			cpu.acc(1'b0, `WTBAC_ADR_FLAG, 8'h00, q);
			chk("cap_flag", {15'h0000, q[3]}, 16'h0001);
			cpu.rd16(`WTBAC_ADR_CAP_LO, r);
			chk("cap_val", r, pair(v[15:8], v[7:0]));
			cpu.acc(1'b1, `WTBAC_ADR_FLAG, 8'h08, q);
		end
		conclude();
	end
endmodule // wide_timer_byte_access_core_tb

`default_nettype wire
